// [include/itfd_pkg.sv]
// Package for the input terminal function decoder: codes, layouts and types
package itfd_pkg;
   localparam int NUM_TERM = 9;
   localparam int CODE_W = 7;
   localparam int FREQ_W = 16;
   localparam int CNT_W = 16;
   localparam logic [CODE_W-1:0] FN_NONE = 7'h00;
   localparam logic [CODE_W-1:0] FN_MS1 = 7'h10;
   localparam logic [CODE_W-1:0] FN_MS2 = 7'h11;
   localparam logic [CODE_W-1:0] FN_MS3 = 7'h12;
   localparam logic [CODE_W-1:0] FN_MS4 = 7'h13;
   localparam logic [CODE_W-1:0] FN_RAMP1 = 7'h15;
   localparam logic [CODE_W-1:0] FN_RAMP2 = 7'h16;
   localparam logic [CODE_W-1:0] FN_WOB_PAUSE = 7'h1a;
   localparam logic [CODE_W-1:0] FN_WOB_RESET = 7'h1b;
   localparam logic [CODE_W-1:0] FN_CNT_RESET = 7'h1c;
   localparam logic [CODE_W-1:0] FN_MODE_SW = 7'h1d;
   localparam logic [CODE_W-1:0] FN_FREEZE = 7'h1e;
   localparam logic [CODE_W-1:0] FN_CNT_TRIG = 7'h1f;
   localparam logic [CODE_W-1:0] FN_TRIM_CLR = 7'h21;
   localparam logic [CODE_W-1:0] FN_DC_BRAKE = 7'h22;
   localparam logic [CODE_W-1:0] FN_SRC_KEY = 7'h24;
   localparam logic [CODE_W-1:0] FN_SRC_TERM = 7'h25;
   localparam logic [CODE_W-1:0] FN_SRC_COMM = 7'h26;
   localparam logic [FREQ_W-1:0] FREQ_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [2:0] SYNC_RST = 3'h0;

   typedef enum logic [1:0]
   {
      ITFD_SRC_KEY = 2'b00,
      ITFD_SRC_TERM = 2'b01,
      ITFD_SRC_COMM = 2'b10
   } itfd_src_e;

   typedef enum logic
   {
      ITFD_MODE_SPEED = 1'b0,
      ITFD_MODE_TORQUE = 1'b1
   } itfd_mode_e;

   typedef struct packed
   {
      logic [3:0] speedIndex;
      logic [1:0] rampSet;
      logic wobblePause;
      logic dcBrake;
      logic rampFreeze;
      logic trimClear;
   } itfd_act_s;
endpackage

// [hdl/itfd_decoder.sv]
// Input terminal function decoder: maps terminal functions to drive actions
`timescale 1ns/10ps
module itfd_decoder
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Terminals and their function codes
   input wire logic [itfd_pkg::NUM_TERM-1:0] termIn,
   input wire logic [itfd_pkg::NUM_TERM*itfd_pkg::CODE_W-1:0] termCode,
   // Core inputs
   input wire logic [1:0] cfgSource,
   input wire logic [itfd_pkg::FREQ_W-1:0] outFreqIn,
   input wire logic [itfd_pkg::FREQ_W-1:0] wobbleFreq,
   input wire logic [itfd_pkg::FREQ_W-1:0] wobbleCenter,
   input wire logic [itfd_pkg::FREQ_W-1:0] trimmedFreq,
   input wire logic [itfd_pkg::FREQ_W-1:0] channelFreq,
   input wire logic stopCmd,
   input wire logic pulseIn,
   // Decoded outputs
   output itfd_pkg::itfd_act_s act,
   output logic [itfd_pkg::FREQ_W-1:0] setFreq,
   output logic [itfd_pkg::FREQ_W-1:0] refFreq,
   output logic [itfd_pkg::CNT_W-1:0] pulseCount,
   output itfd_pkg::itfd_mode_e ctrlMode,
   output itfd_pkg::itfd_src_e runSource,
   output logic stopOut
);

////////////////////////////////////////////////////////////////////////////////
// Reset release
logic [1:0] rstSync;
logic rstLocal_n;

always_ff @(posedge clk_sys or negedge rst_n)
begin
   if (!rst_n)
      rstSync <= 2'h0;
   else
      rstSync <= {rstSync[0], 1'b1};
end
assign rstLocal_n = rstSync[1];

////////////////////////////////////////////////////////////////////////////////
// Terminal and pulse synchronisers; a change counts when stages two and three agree
logic [itfd_pkg::NUM_TERM-1:0] termLvl;
logic pulseLvl;

genvar gi;
generate
   for (gi = 0; gi <= itfd_pkg::NUM_TERM; gi++)
   begin : gSync
      logic [2:0] sh;
      logic lvl;
      logic next_lvl;
      logic rawIn;
      if (gi < itfd_pkg::NUM_TERM)
      begin : gT
         assign rawIn = termIn[gi];
         assign termLvl[gi] = lvl;
      end
      else
      begin : gP
         assign rawIn = pulseIn;
         assign pulseLvl = lvl;
      end
      always_comb
      begin
         next_lvl = (sh[1] == sh[2]) ? sh[2] : lvl;
      end
      always_ff @(posedge clk_sys or negedge rstLocal_n)
      begin
         if (!rstLocal_n)
         begin
            sh <= itfd_pkg::SYNC_RST;
            lvl <= 1'b0;
         end
         else
         begin
            sh <= {sh[1:0], rawIn};
            lvl <= next_lvl;
         end
      end
   end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Function decode: OR of every active terminal carrying each code
logic fMs1, fMs2, fMs3, fMs4, fRamp1, fRamp2, fWobP, fWobR, fCntR, fMode;
logic fFreeze, fCntT, fTrim, fDc, fKey, fTerm, fComm;
logic anyCoded;

always_comb
begin
   logic [itfd_pkg::CODE_W-1:0] c;
   c = '0;
   {fMs1, fMs2, fMs3, fMs4, fRamp1, fRamp2, fWobP, fWobR, fCntR} = '0;
   {fMode, fFreeze, fCntT, fTrim, fDc, fKey, fTerm, fComm} = '0;
   anyCoded = 1'b0;
   for (int i = 0; i < itfd_pkg::NUM_TERM; i++)
   begin
      c = termCode[i*itfd_pkg::CODE_W +: itfd_pkg::CODE_W];
      // Code zero matches no function below, so such a terminal does nothing
      if (termLvl[i] && c != itfd_pkg::FN_NONE)
      begin
         fMs1 |= (c == itfd_pkg::FN_MS1);
         fMs2 |= (c == itfd_pkg::FN_MS2);
         fMs3 |= (c == itfd_pkg::FN_MS3);
         fMs4 |= (c == itfd_pkg::FN_MS4);
         fRamp1 |= (c == itfd_pkg::FN_RAMP1);
         fRamp2 |= (c == itfd_pkg::FN_RAMP2);
         fWobP |= (c == itfd_pkg::FN_WOB_PAUSE);
         fWobR |= (c == itfd_pkg::FN_WOB_RESET);
         fCntR |= (c == itfd_pkg::FN_CNT_RESET);
         fMode |= (c == itfd_pkg::FN_MODE_SW);
         fFreeze |= (c == itfd_pkg::FN_FREEZE);
         fCntT |= (c == itfd_pkg::FN_CNT_TRIG);
         fTrim |= (c == itfd_pkg::FN_TRIM_CLR);
         fDc |= (c == itfd_pkg::FN_DC_BRAKE);
         fKey |= (c == itfd_pkg::FN_SRC_KEY);
         fTerm |= (c == itfd_pkg::FN_SRC_TERM);
         fComm |= (c == itfd_pkg::FN_SRC_COMM);
         anyCoded = 1'b1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Registered actions and state
logic prevWobR, prevCntR, prevMode, prevPulse;
logic next_prevWobR, next_prevCntR, next_prevMode, next_prevPulse;
itfd_pkg::itfd_act_s next_act;
logic [itfd_pkg::FREQ_W-1:0] next_setFreq, next_refFreq;
logic [itfd_pkg::CNT_W-1:0] next_pulseCount;
itfd_pkg::itfd_mode_e next_ctrlMode;
itfd_pkg::itfd_src_e next_runSource;
logic next_stopOut;

always_comb
begin
   next_prevWobR = fWobR;
   next_prevCntR = fCntR;
   next_prevMode = fMode;
   next_prevPulse = pulseLvl;
   next_act.speedIndex = {fMs4, fMs3, fMs2, fMs1};
   next_act.rampSet = {fRamp2, fRamp1}; // Code 0..3 is set one..four
   next_act.wobblePause = fWobP;
   next_act.dcBrake = fDc;
   next_act.rampFreeze = fFreeze;
   next_act.trimClear = fTrim;
   // Priority: freeze over pause over reset over normal wobble
   if (fFreeze)
      next_setFreq = setFreq;
   else if (fWobP)
      next_setFreq = setFreq; // Wobbling resumes from outFreqIn, or from wobbleFreq if the held value equals outFreqIn
   else if (fWobR && !prevWobR)
      next_setFreq = wobbleCenter;
   else if (!prevWobR || !fWobR)
      next_setFreq = fWobP ? setFreq : (setFreq == outFreqIn ? wobbleFreq : outFreqIn);
   else
      next_setFreq = setFreq;
   next_refFreq = fTrim ? channelFreq : trimmedFreq;
   // Stop passes through freeze untouched
   next_stopOut = stopCmd;
   // Reset edge beats counting in the same cycle
   if (fCntR && !prevCntR)
      next_pulseCount = itfd_pkg::CNT_RST;
   else if (fCntT && pulseLvl && !prevPulse)
      next_pulseCount = pulseCount + itfd_pkg::CNT_ONE;
   else
      next_pulseCount = pulseCount;
   if (fMode && !prevMode)
      next_ctrlMode = (ctrlMode == itfd_pkg::ITFD_MODE_SPEED) ? itfd_pkg::ITFD_MODE_TORQUE
                                                            : itfd_pkg::ITFD_MODE_SPEED;
   else
      next_ctrlMode = ctrlMode;
   // Keypad over terminal over comm; none active falls back to configuration
   if (fKey)
      next_runSource = itfd_pkg::ITFD_SRC_KEY;
   else if (fTerm)
      next_runSource = itfd_pkg::ITFD_SRC_TERM;
   else if (fComm)
      next_runSource = itfd_pkg::ITFD_SRC_COMM;
   else if (cfgSource == 2'h3)
      next_runSource = itfd_pkg::ITFD_SRC_KEY;
   else
      next_runSource = itfd_pkg::itfd_src_e'(cfgSource);
end

always_ff @(posedge clk_sys or negedge rstLocal_n)
begin
   if (!rstLocal_n)
   begin
      prevWobR <= 1'b0;
      prevCntR <= 1'b0;
      prevMode <= 1'b0;
      prevPulse <= 1'b0;
      act <= '0;
      setFreq <= itfd_pkg::FREQ_RST;
      refFreq <= itfd_pkg::FREQ_RST;
      pulseCount <= itfd_pkg::CNT_RST;
      ctrlMode <= itfd_pkg::ITFD_MODE_SPEED;
      runSource <= itfd_pkg::ITFD_SRC_KEY;
      stopOut <= 1'b0;
   end
   else
   begin
      prevWobR <= next_prevWobR;
      prevCntR <= next_prevCntR;
      prevMode <= next_prevMode;
      prevPulse <= next_prevPulse;
      act <= next_act;
      setFreq <= next_setFreq;
      refFreq <= next_refFreq;
      pulseCount <= next_pulseCount;
      ctrlMode <= next_ctrlMode;
      runSource <= next_runSource;
      stopOut <= next_stopOut;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Checks; all stay quiet until the local reset lets go

a_speed_index: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   1'b1 |=> act.speedIndex == $past({fMs4, fMs3, fMs2, fMs1}))
   else $error("speed index wrong");

a_index_range: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   (fMs4 && fMs1 && !fMs2 && !fMs3) |=> act.speedIndex == 4'h9)
   else $error("index bits");

a_ramp_set: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   (fRamp1 && !fRamp2) |=> act.rampSet == 2'h1)
   else $error("ramp set wrong");

a_ramp_four: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   (fRamp1 && fRamp2) |=> act.rampSet == 2'h3)
   else $error("ramp set four wrong");

a_wobble_hold: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   fWobP |=> setFreq == $past(setFreq))
   else $error("pause did not hold");

a_wobble_reset: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   (fWobR && !prevWobR && !fWobP && !fFreeze) |=> setFreq == $past(wobbleCenter))
   else $error("reset not to center");

a_count_clear: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   (fCntR && !prevCntR) |=> pulseCount == itfd_pkg::CNT_RST)
   else $error("counter not cleared");

a_count_gate: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   !fCntT |=> pulseCount == itfd_pkg::CNT_RST || pulseCount == $past(pulseCount))
   else $error("counted untriggered");

a_count_step: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   (fCntT && pulseLvl && !prevPulse && !(fCntR && !prevCntR))
   |=> pulseCount == $past(pulseCount) + itfd_pkg::CNT_ONE)
   else $error("pulse not counted");

a_mode_toggle: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   (fMode && !prevMode) |=> ctrlMode != $past(ctrlMode))
   else $error("mode not toggled");

a_mode_hold: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   !(fMode && !prevMode) |=> ctrlMode == $past(ctrlMode))
   else $error("mode changed unasked");

a_freeze_stop: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   fFreeze |=> setFreq == $past(setFreq) && stopOut == $past(stopCmd))
   else $error("freeze broken");

a_stop_pass: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   1'b1 |=> stopOut == $past(stopCmd))
   else $error("stop not passed");

a_trim_clear: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   1'b1 |=> refFreq == ($past(fTrim) ? $past(channelFreq) : $past(trimmedFreq)))
   else $error("trim select wrong");

a_dc_brake: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   $rose(fDc) |=> act.dcBrake)
   else $error("brake late");

a_key_source: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   fKey |=> runSource == itfd_pkg::ITFD_SRC_KEY)
   else $error("keypad source lost");

a_term_source: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   (fTerm && !fKey) |=> runSource == itfd_pkg::ITFD_SRC_TERM)
   else $error("terminal source lost");

a_comm_source: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   (fComm && !fKey && !fTerm) |=> runSource == itfd_pkg::ITFD_SRC_COMM)
   else $error("comm source lost");

a_src_fallback: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   (!fKey && !fTerm && !fComm && cfgSource != 2'h3) |=> runSource == $past(cfgSource))
   else $error("source not restored");

a_code_zero: assert property (@(posedge clk_sys) disable iff (!rstLocal_n)
   !anyCoded |=> act == '0)
   else $error("code zero acted");

endmodule

// [tb/itfd_contacts.sv]
// Model of the contacts and the pulse source wired to the input terminals
`timescale 1ns/10ps
module itfd_contacts
(
   // Requested contact states
   input wire logic [8:0] want,
   input wire logic pulseWant,
   // Terminal pins
   output logic [8:0] termIn,
   output logic pulseIn
);
   // Contacts switch well away from the clock edge, like real ones
   initial
   begin
      termIn = 9'h000;
      forever @(want) termIn <= #7 want;
   end
   initial
   begin
      pulseIn = 1'b0;
      forever @(pulseWant) pulseIn <= #7 pulseWant;
   end
endmodule

// [tb/tb.sv]
// Self-checking testbench for the input terminal function decoder
`timescale 1ns/10ps
module tb;
   typedef struct {int sel; logic [15:0] exp;} itfd_note_s;
   logic clk_sys, rst_n, stopCmd, pulseWant, chkStb;
   logic [8:0] want, termIn;
   logic pulseIn;
   logic [itfd_pkg::NUM_TERM*itfd_pkg::CODE_W-1:0] termCode;
   logic [1:0] cfgSource;
   logic [15:0] outFreqIn, wobbleFreq, wobbleCenter, trimmedFreq, channelFreq, setFreq, refFreq, pulseCount;
   itfd_pkg::itfd_act_s act;
   itfd_pkg::itfd_mode_e ctrlMode;
   itfd_pkg::itfd_src_e runSource;
   logic stopOut;
   itfd_note_s notes[$];
   itfd_note_s note;
   int nErrors = 0;
   int numChecks = 0;
   logic [15:0] lfsr = 16'h0014;
   string selName[13] = '{"speedIndex", "rampSet", "dcBrake", "rampFreeze", "trimClear", "refFreq", "setFreq",
      "pulseCount", "ctrlMode", "runSource", "stopOut", "act", "wobblePause"};

   itfd_contacts contacts (.want(want), .pulseWant(pulseWant), .termIn(termIn), .pulseIn(pulseIn));
   itfd_decoder DUT (.clk_sys(clk_sys), .rst_n(rst_n), .termIn(termIn), .termCode(termCode),
      .cfgSource(cfgSource), .outFreqIn(outFreqIn), .wobbleFreq(wobbleFreq), .wobbleCenter(wobbleCenter),
      .trimmedFreq(trimmedFreq), .channelFreq(channelFreq), .stopCmd(stopCmd), .pulseIn(pulseIn), .act(act),
      .setFreq(setFreq), .refFreq(refFreq), .pulseCount(pulseCount), .ctrlMode(ctrlMode),
      .runSource(runSource), .stopOut(stopOut));

   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] nextRand(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   function automatic logic [15:0] obs(input int sel);
      case (sel)
         0: return {12'h000, act.speedIndex};
         1: return {14'h0000, act.rampSet};
         2: return {15'h0000, act.dcBrake};
         3: return {15'h0000, act.rampFreeze};
         4: return {15'h0000, act.trimClear};
         5: return refFreq;
         6: return setFreq;
         7: return pulseCount;
         8: return {15'h0000, ctrlMode};
         9: return {14'h0000, runSource};
         10: return {15'h0000, stopOut};
         11: return {6'h00, act};
         default: return {15'h0000, act.wobblePause};
      endcase
   endfunction

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      numChecks++;
      if (seen !== exp)
      begin
         nErrors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic completeRun();
      $display("Checks %0d errors %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Notes the result due now; the monitor compares it at the next edge
   // Two edges per call, so the strobe never moves twice in one step
   task automatic expectOut(input int sel, input logic [15:0] exp);
      notes.push_back('{sel, exp});
      chkStb <= 1'b1;
      @(posedge clk_sys);
      chkStb <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic setPins(input logic [8:0] v);
      want <= v;
      repeat (8) @(posedge clk_sys);
   endtask

   task automatic setFreqs(input logic [15:0] f);
      outFreqIn <= f;
      wobbleFreq <= f;
      repeat (8) @(posedge clk_sys);
   endtask

   task automatic pulses(input int n);
      repeat (n)
      begin
         pulseWant <= 1'b1;
         repeat (4) @(posedge clk_sys);
         pulseWant <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
   endtask

   always @(posedge clk_sys)
      if (chkStb === 1'b1 && notes.size() > 0)
      begin
         note = notes.pop_front();
         check(selName[note.sel], obs(note.sel), note.exp);
      end

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      nErrors++;
      completeRun();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_n = 1'b0;
      want = 9'h000;
      stopCmd = 1'b0;
      pulseWant = 1'b0;
      chkStb = 1'b0;
      termCode = {itfd_pkg::FN_FREEZE, itfd_pkg::FN_TRIM_CLR, itfd_pkg::FN_DC_BRAKE, itfd_pkg::FN_RAMP2,
         itfd_pkg::FN_RAMP1, itfd_pkg::FN_MS4, itfd_pkg::FN_MS3, itfd_pkg::FN_MS2, itfd_pkg::FN_MS1};
      cfgSource = 2'h2;
      outFreqIn = 16'h1234;
      wobbleFreq = 16'h1234;
      wobbleCenter = 16'h0800;
      trimmedFreq = 16'h0a00;
      channelFreq = 16'h0500;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      for (int k = 0; k < 24; k++)
      begin
         lfsr = nextRand(lfsr);
         stopCmd <= lfsr[9];
         channelFreq <= {lfsr[7:0], lfsr[15:8]};
         setPins(lfsr[8:0]);
         expectOut(0, {12'h000, lfsr[3:0]});
         expectOut(1, {14'h0000, lfsr[5:4]});
         expectOut(2, {15'h0000, lfsr[6]});
         expectOut(4, {15'h0000, lfsr[7]});
         expectOut(5, lfsr[7] ? {lfsr[7:0], lfsr[15:8]} : 16'h0a00);
         expectOut(3, {15'h0000, lfsr[8]});
         expectOut(10, {15'h0000, lfsr[9]});
      end
      // Freeze holds the frequency while a stop still gets through
      setPins(9'h000);
      setFreqs(16'h1111);
      setPins(9'h100);
      stopCmd <= 1'b0;
      setFreqs(16'h2222);
      stopCmd <= 1'b1;
      expectOut(6, 16'h1111);
      expectOut(10, 16'h0001);
      setPins(9'h000);
      expectOut(6, 16'h2222);
      termCode <= {itfd_pkg::FN_NONE, itfd_pkg::FN_SRC_COMM, itfd_pkg::FN_SRC_TERM, itfd_pkg::FN_SRC_KEY,
         itfd_pkg::FN_CNT_TRIG, itfd_pkg::FN_MODE_SW, itfd_pkg::FN_CNT_RESET, itfd_pkg::FN_WOB_RESET,
         itfd_pkg::FN_WOB_PAUSE};
      setPins(9'h100);
      expectOut(11, 16'h0000);
      expectOut(9, 16'h0002);
      expectOut(8, 16'h0000);
      setPins(9'h040);
      expectOut(9, 16'h0001);
      setPins(9'h000);
      expectOut(9, 16'h0002);
      setPins(9'h0a0);
      expectOut(9, 16'h0000);
      setPins(9'h000);
      expectOut(9, 16'h0002);
      cfgSource <= 2'h0;
      setPins(9'h080);
      expectOut(9, 16'h0002);
      setPins(9'h000);
      expectOut(9, 16'h0000);
      cfgSource <= 2'h3;
      setPins(9'h040);
      expectOut(9, 16'h0001);
      setPins(9'h000);
      expectOut(9, 16'h0000);
      for (int k = 0; k < 2; k++)
      begin
         setPins(9'h008);
         setPins(9'h000);
         expectOut(8, k == 0 ? 16'h0001 : 16'h0000);
      end
      setFreqs(16'h3333);
      setPins(9'h001);
      expectOut(12, 16'h0001);
      setFreqs(16'h4444);
      expectOut(6, 16'h3333);
      setPins(9'h000);
      expectOut(6, 16'h4444);
      setPins(9'h002);
      expectOut(6, 16'h0800);
      setPins(9'h000);
      pulses(3);
      expectOut(7, 16'h0000);
      setPins(9'h010);
      pulses(5);
      repeat (6) @(posedge clk_sys);
      expectOut(7, 16'h0005);
      setPins(9'h014);
      expectOut(7, 16'h0000);
      setPins(9'h010);
      pulses(2);
      repeat (6) @(posedge clk_sys);
      expectOut(7, 16'h0002);
      repeat (2) @(posedge clk_sys);
      completeRun();
   end
endmodule
